//--- src/mps_pkg.sv
// Constants, types and helpers for the MII pin strap and interrupt block.
// Assumes a single 40 MHz system clock and a synchronous active-high reset.
//
// Behaviour
// - Reset samples rxd3..1 as address bits 0..2
// - Reset loads rxd0 into control bit 8
// - Reset captures rx valid as mode bit 2
// - Reset captures rx error as isolate strap
// - After reset, drive rx data, valid, error while control bit 10 (isolate) is clear
// - Drive receive and transmit clocks as outputs
// - Interrupt follows enables and status in 1Bh
// - Bit 9 of 1Fh sets interrupt polarity
// - Management bits move with management clock
// - Decode three-bit interface mode strap
// - Station address bits 4:3 forced zero
// - Reset loads isolate strap into bit 10
package mps_pkg;
    localparam int REG_AW = 5;
    localparam int REG_DW = 16;
    localparam int NUM_EVENTS = 8;

    localparam logic [4:0] ADDR_CTRL0 = 5'h00;
    localparam logic [4:0] ADDR_STRAP = 5'h19;
    localparam logic [4:0] ADDR_IRQ = 5'h1b;
    localparam logic [4:0] ADDR_CTRL1F = 5'h1f;

    localparam int CTRL0_DUPLEX_BIT = 8;
    localparam int CTRL0_ISOLATE_BIT = 10;
    localparam int CTRL1F_IRQ_POL_BIT = 9;
    localparam int IRQ_EN_LSB = 8;
    localparam int IRQ_STAT_LSB = 0;

    localparam logic [15:0] CTRL0_RST = 16'h0000;
    localparam logic [15:0] CTRL1F_RST = 16'h0000;
    localparam logic [7:0] IRQ_EN_RST = 8'h00;
    localparam logic [1:0] ADDR_HIGH_FORCED = 2'h0;

    localparam logic [5:0] MDIO_PRE_MIN = 6'h20;
    localparam logic [4:0] MDIO_HDR_LAST = 5'h0b;
    localparam logic [4:0] MDIO_TA_DRIVE = 5'h01;
    localparam logic [4:0] MDIO_RD_LAST = 5'h11;
    localparam logic [4:0] MDIO_RD_END = 5'h12;
    localparam logic [4:0] MDIO_WR_FIRST = 5'h02;
    localparam logic [4:0] MDIO_WR_LAST = 5'h11;
    localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
    localparam logic [1:0] MDIO_OP_READ = 2'h2;

    localparam int CLK_PERIOD_NS = 25;
    localparam int MII_CLK_HALF_NS = 200;
    localparam int MII_CLK_HALF_CYC = (MII_CLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        MPS_MODE_MII = 3'b000,
        MPS_MODE_RMII = 3'b001,
        MPS_MODE_SMII = 3'b010,
        MPS_MODE_RSVD3 = 3'b011,
        MPS_MODE_MII_PRE = 3'b100,
        MPS_MODE_RMII_B2B = 3'b101,
        MPS_MODE_MII_B2B = 3'b110,
        MPS_MODE_RSVD7 = 3'b111
    } mps_mode_t;

    typedef enum logic [1:0] {
        MPS_MD_IDLE = 2'b00,
        MPS_MD_START = 2'b01,
        MPS_MD_HDR = 2'b10,
        MPS_MD_XFER = 2'b11
    } mps_md_state_t;

    typedef struct packed {
        logic dv;
        logic er;
        logic [3:0] data;
    } mps_rx_t;

    typedef struct packed {
        logic [2:0] addr;
        logic duplex;
        logic mode_bit2;
        logic isolate;
    } mps_strap_t;

    function automatic logic mps_mode_reserved(input mps_mode_t m);
        mps_mode_reserved = (m == MPS_MODE_RSVD3) || (m == MPS_MODE_RSVD7);
    endfunction : mps_mode_reserved
endpackage : mps_pkg

//--- src/mps_strap_irq.sv
// Shared MII pin logic: strap capture, receive drivers, clocks, management port, interrupt.
// Assumes pins arrive asynchronously; event_in, rx_src and cfg_low_strap are on clock.
`timescale 1ns/1ps
module mps_strap_irq #(
    parameter int CLK_HALF_CYC = mps_pkg::MII_CLK_HALF_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire mps_pkg::mps_rx_t rx_pin_in,
    output mps_pkg::mps_rx_t rx_pin_out,
    output logic rx_pin_oe_n,
    input wire mps_pkg::mps_rx_t rx_src,
    output logic rx_clk_out,
    output logic tx_clk_out,
    input wire logic tx_en_pin,
    input wire logic [3:0] txd_pin,
    output logic tx_en,
    output logic [3:0] txd,
    input wire logic mdc_pin,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    input wire logic [1:0] cfg_low_strap,
    input wire logic [7:0] event_in,
    output logic [4:0] station_address,
    output mps_pkg::mps_mode_t iface_mode,
    output logic iface_mode_reserved,
    output logic duplex_mode,
    output logic isolate_mode,
    output logic irq_out
);
    // Synchronisers: first stage feeds only the second
    mps_pkg::mps_rx_t rx_s1, rx_s2;
    logic [1:0] mgmt_s1, mgmt_s2;
    logic [4:0] tx_s1, tx_s2;
    logic mdc_prev;

    always_ff @(posedge clock) begin
        rx_s1 <= rx_pin_in;
        rx_s2 <= rx_s1;
        mgmt_s1 <= {mdc_pin, mdio_in};
        mgmt_s2 <= mgmt_s1;
        tx_s1 <= {tx_en_pin, txd_pin};
        tx_s2 <= tx_s1;
        mdc_prev <= mgmt_s2[1];
    end

    wire mdc_rise = mgmt_s2[1] & ~mdc_prev;
    wire mdc_fall = ~mgmt_s2[1] & mdc_prev;
    wire mdio_bit = mgmt_s2[0];

    // Strap capture
    mps_pkg::mps_strap_t strap, next_strap;
    mps_pkg::mps_strap_t pin_strap;
    logic [1:0] low_strap, next_low_strap;

    always_comb begin
        pin_strap.addr = {rx_s2.data[1], rx_s2.data[2], rx_s2.data[3]};
        pin_strap.duplex = rx_s2.data[0];
        pin_strap.mode_bit2 = rx_s2.dv;
        pin_strap.isolate = rx_s2.er;
        // Last sample before release is kept until the next reset
        next_strap = sys_rst ? pin_strap : strap;
        // Low mode bits frozen too, so a late change cannot move the mode
        next_low_strap = sys_rst ? cfg_low_strap : low_strap;
    end

    always_ff @(posedge clock) begin
        strap <= next_strap;
        low_strap <= next_low_strap;
    end

    // Register file and interrupt
    logic [15:0] ctrl0, next_ctrl0;
    logic [15:0] ctrl1f, next_ctrl1f;
    logic [7:0] irq_en, next_irq_en;
    logic [7:0] irq_stat, next_irq_stat;
    logic [15:0] next_reg_rdata;
    logic next_irq_out;
    logic mdio_wr;
    logic [4:0] mdio_waddr;
    logic [15:0] mdio_wdata;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [15:0] wr_data;
    logic irq_act;

    function automatic logic [15:0] read_mux(input logic [4:0] a);
        unique case (a)
            mps_pkg::ADDR_CTRL0: read_mux = ctrl0;
            mps_pkg::ADDR_IRQ: read_mux = {irq_en, irq_stat};
            mps_pkg::ADDR_CTRL1F: read_mux = ctrl1f;
            mps_pkg::ADDR_STRAP: read_mux = {8'h00, strap.addr, low_strap, strap.duplex,
                                             strap.mode_bit2, strap.isolate};
            default: read_mux = 16'h0000;
        endcase
    endfunction : read_mux

    always_comb begin
        // Bus write wins a collision with a management write
        wr_en = reg_wr | mdio_wr;
        wr_addr = reg_wr ? reg_addr : mdio_waddr;
        wr_data = reg_wr ? reg_wdata : mdio_wdata;
        next_ctrl0 = ctrl0;
        next_ctrl1f = ctrl1f;
        next_irq_en = irq_en;
        next_irq_stat = irq_stat;
        if (wr_en && wr_addr == mps_pkg::ADDR_CTRL0) begin
            next_ctrl0 = wr_data;
        end
        if (wr_en && wr_addr == mps_pkg::ADDR_CTRL1F) begin
            next_ctrl1f = wr_data;
        end
        if (wr_en && wr_addr == mps_pkg::ADDR_IRQ) begin
            next_irq_en = wr_data[mps_pkg::IRQ_EN_LSB +: 8];
            next_irq_stat = irq_stat & ~wr_data[mps_pkg::IRQ_STAT_LSB +: 8];
        end
        // Set after clear so a same-cycle event survives
        next_irq_stat = next_irq_stat | event_in;
        next_reg_rdata = reg_rd ? read_mux(reg_addr) : 16'h0000;
        irq_act = |(irq_stat & irq_en);
        next_irq_out = ctrl1f[mps_pkg::CTRL1F_IRQ_POL_BIT] ? irq_act : ~irq_act;
        if (sys_rst) begin
            next_ctrl0 = mps_pkg::CTRL0_RST;
            next_ctrl0[mps_pkg::CTRL0_DUPLEX_BIT] = pin_strap.duplex;
            next_ctrl0[mps_pkg::CTRL0_ISOLATE_BIT] = pin_strap.isolate;
            next_ctrl1f = mps_pkg::CTRL1F_RST;
            next_irq_en = mps_pkg::IRQ_EN_RST;
            next_irq_stat = 8'h00;
            next_reg_rdata = 16'h0000;
            next_irq_out = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        ctrl0 <= next_ctrl0;
        ctrl1f <= next_ctrl1f;
        irq_en <= next_irq_en;
        irq_stat <= next_irq_stat;
        reg_rdata <= next_reg_rdata;
        irq_out <= next_irq_out;
    end

    // Status outputs
    logic [4:0] next_station_address;
    mps_pkg::mps_mode_t next_iface_mode;
    logic next_mode_rsvd;

    always_comb begin
        next_station_address = {mps_pkg::ADDR_HIGH_FORCED, strap.addr};
        next_iface_mode = mps_pkg::mps_mode_t'({strap.mode_bit2, low_strap});
        next_mode_rsvd = mps_pkg::mps_mode_reserved(next_iface_mode);
    end

    always_ff @(posedge clock) begin
        station_address <= next_station_address;
        iface_mode <= next_iface_mode;
        iface_mode_reserved <= next_mode_rsvd;
        duplex_mode <= ctrl0[mps_pkg::CTRL0_DUPLEX_BIT];
        isolate_mode <= ctrl0[mps_pkg::CTRL0_ISOLATE_BIT];
    end

    // MII clocks and data pins
    logic [7:0] div_cnt, next_div_cnt;
    logic mii_clk, next_mii_clk;
    logic next_oe_n;
    mps_pkg::mps_rx_t next_rx_pin_out;
    logic next_tx_en;
    logic [3:0] next_txd;
    logic div_wrap;

    always_comb begin
        div_wrap = (div_cnt == 8'(CLK_HALF_CYC - 1));
        next_div_cnt = div_wrap ? 8'h00 : div_cnt + 8'h01;
        next_mii_clk = div_wrap ? ~mii_clk : mii_clk;
        // Isolate releases the shared pins as well
        next_oe_n = sys_rst | ctrl0[mps_pkg::CTRL0_ISOLATE_BIT];
        next_rx_pin_out = rx_pin_out;
        if (div_wrap && mii_clk) begin
            next_rx_pin_out = rx_src;
        end
        next_tx_en = tx_en;
        next_txd = txd;
        if (div_wrap && !mii_clk) begin
            next_tx_en = tx_s2[4];
            next_txd = tx_s2[3:0];
        end
        if (sys_rst) begin
            next_div_cnt = 8'h00;
            next_mii_clk = 1'b0;
            next_rx_pin_out = '0;
            next_tx_en = 1'b0;
            next_txd = 4'h0;
        end
    end

    always_ff @(posedge clock) begin
        div_cnt <= next_div_cnt;
        mii_clk <= next_mii_clk;
        rx_pin_oe_n <= next_oe_n;
        rx_pin_out <= next_rx_pin_out;
        tx_en <= next_tx_en;
        txd <= next_txd;
    end

    assign rx_clk_out = mii_clk;
    assign tx_clk_out = mii_clk;

    // Management frame engine
    mps_pkg::mps_md_state_t md_state, next_md_state;
    logic [5:0] pre_cnt, next_pre_cnt;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [15:0] shreg, next_shreg;
    logic is_read, next_is_read;
    logic [4:0] next_mdio_waddr;
    logic next_mdio_wr;
    logic [15:0] next_mdio_wdata;
    logic next_mdio_out, next_mdio_oe_n;
    logic [11:0] hdr;

    always_comb begin
        next_md_state = md_state;
        next_pre_cnt = pre_cnt;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_is_read = is_read;
        next_mdio_waddr = mdio_waddr;
        next_mdio_wr = 1'b0;
        next_mdio_wdata = mdio_wdata;
        next_mdio_out = mdio_out;
        next_mdio_oe_n = mdio_oe_n;
        hdr = {shreg[10:0], mdio_bit};
        unique case (md_state)
            mps_pkg::MPS_MD_IDLE: begin
                if (mdc_rise) begin
                    if (mdio_bit) begin
                        next_pre_cnt = (pre_cnt == mps_pkg::MDIO_PRE_MIN) ? pre_cnt : pre_cnt + 6'h01;
                    end else begin
                        if (pre_cnt == mps_pkg::MDIO_PRE_MIN) begin
                            next_md_state = mps_pkg::MPS_MD_START;
                        end
                        next_pre_cnt = 6'h00;
                    end
                end
            end
            mps_pkg::MPS_MD_START: begin
                if (mdc_rise) begin
                    next_md_state = mdio_bit ? mps_pkg::MPS_MD_HDR : mps_pkg::MPS_MD_IDLE;
                    next_bit_cnt = 5'h00;
                end
            end
            mps_pkg::MPS_MD_HDR: begin
                if (mdc_rise) begin
                    next_shreg = {shreg[14:0], mdio_bit};
                    next_bit_cnt = bit_cnt + 5'h01;
                    if (bit_cnt == mps_pkg::MDIO_HDR_LAST) begin
                        next_bit_cnt = 5'h00;
                        next_md_state = mps_pkg::MPS_MD_IDLE;
                        next_mdio_waddr = hdr[4:0];
                        next_is_read = (hdr[11:10] == mps_pkg::MDIO_OP_READ);
                        if (hdr[9:5] == station_address &&
                            (hdr[11:10] == mps_pkg::MDIO_OP_READ || hdr[11:10] == mps_pkg::MDIO_OP_WRITE)) begin
                            next_md_state = mps_pkg::MPS_MD_XFER;
                            next_shreg = read_mux(hdr[4:0]);
                        end
                    end
                end
            end
            mps_pkg::MPS_MD_XFER: begin
                if (is_read && mdc_fall) begin
                    next_bit_cnt = bit_cnt + 5'h01;
                    if (bit_cnt == mps_pkg::MDIO_TA_DRIVE) begin
                        next_mdio_oe_n = 1'b0;
                        next_mdio_out = 1'b0;
                    end else if (bit_cnt > mps_pkg::MDIO_TA_DRIVE && bit_cnt <= mps_pkg::MDIO_RD_LAST) begin
                        next_mdio_out = shreg[15];
                        next_shreg = {shreg[14:0], 1'b0};
                    end else if (bit_cnt == mps_pkg::MDIO_RD_END) begin
                        next_mdio_oe_n = 1'b1;
                        next_mdio_out = 1'b0;
                        next_md_state = mps_pkg::MPS_MD_IDLE;
                    end
                end
                if (!is_read && mdc_rise) begin
                    next_bit_cnt = bit_cnt + 5'h01;
                    if (bit_cnt >= mps_pkg::MDIO_WR_FIRST) begin
                        next_shreg = {shreg[14:0], mdio_bit};
                    end
                    if (bit_cnt == mps_pkg::MDIO_WR_LAST) begin
                        next_mdio_wr = 1'b1;
                        next_mdio_wdata = {shreg[14:0], mdio_bit};
                        next_md_state = mps_pkg::MPS_MD_IDLE;
                    end
                end
            end
        endcase
        if (sys_rst) begin
            next_md_state = mps_pkg::MPS_MD_IDLE;
            next_pre_cnt = 6'h00;
            next_bit_cnt = 5'h00;
            next_shreg = 16'h0000;
            next_is_read = 1'b0;
            next_mdio_waddr = 5'h00;
            next_mdio_wr = 1'b0;
            next_mdio_wdata = 16'h0000;
            next_mdio_out = 1'b0;
            next_mdio_oe_n = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        md_state <= next_md_state;
        pre_cnt <= next_pre_cnt;
        bit_cnt <= next_bit_cnt;
        shreg <= next_shreg;
        is_read <= next_is_read;
        mdio_waddr <= next_mdio_waddr;
        mdio_wr <= next_mdio_wr;
        mdio_wdata <= next_mdio_wdata;
        mdio_out <= next_mdio_out;
        mdio_oe_n <= next_mdio_oe_n;
    end
endmodule : mps_strap_irq

//--- tb/mps_strap_irq_properties.sv
// Checker for the strap, pin drive, clock and interrupt behaviour at the block's ports.
// Assumes one clock domain with a synchronous active-high reset; attached by bind.
`timescale 1ns/1ps
module mps_strap_irq_properties #(
    parameter int CLK_HALF_CYC = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [7:0] event_in,
    input wire logic irq_out,
    input wire logic rx_pin_oe_n,
    input wire logic mdio_oe_n,
    input wire logic rx_clk_out,
    input wire logic tx_clk_out,
    input wire logic [4:0] station_address,
    input wire mps_pkg::mps_mode_t iface_mode,
    input wire logic iface_mode_reserved,
    input wire logic isolate_mode
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // Quiet inputs leave the interrupt level alone two edges on
    property irq_quiet_p;
        !reg_wr && event_in == 8'h00 |-> ##2 irq_out == $past(irq_out);
    endproperty

    addr_high_zero_a: assert property (station_address[4:3] == 2'b00)
        else $error("station address upper bits not zero");
    strap_hold_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
        $stable(station_address) && $stable(iface_mode)) else $error("strap values moved outside reset");
    mode_reserved_a: assert property (iface_mode_reserved ==
        (iface_mode == mps_pkg::MPS_MODE_RSVD3 || iface_mode == mps_pkg::MPS_MODE_RSVD7))
        else $error("reserved mode flag wrong");
    pins_off_reset_a: assert property (disable iff (1'b0) $past(sys_rst) |-> rx_pin_oe_n && mdio_oe_n)
        else $error("pins driven during reset");
    pins_on_release_a: assert property ($fell(sys_rst) |=> rx_pin_oe_n == isolate_mode)
        else $error("rx pin drive wrong after reset");
    clocks_same_a: assert property (rx_clk_out == tx_clk_out)
        else $error("receive and transmit clocks differ");
    clock_half_a: assert property ($rose(rx_clk_out) |-> ##[1:CLK_HALF_CYC] !rx_clk_out)
        else $error("receive clock high too long");
    clock_low_a: assert property ($fell(rx_clk_out) |-> ##[1:CLK_HALF_CYC] rx_clk_out)
        else $error("receive clock low too long");
    irq_quiet_a: assert property (irq_quiet_p)
        else $error("interrupt moved without cause");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read slot");

    cover property (!irq_out ##1 irq_out);
    cover property ($fell(mdio_oe_n));
    cover property ($fell(rx_pin_oe_n));
endmodule : mps_strap_irq_properties

//--- tb/mps_mac_model.sv
// Model of the MAC and management master on the far side of the pins.
// Assumes the bench resolves the pulled-up management data wire.
`timescale 1ns/1ps
module mps_mac_model (
    input wire logic clock,
    input wire logic tx_clk_out,
    input wire logic [4:0] tx_val,
    input wire logic mdio_wire,
    output logic tx_en_pin,
    output logic [3:0] txd_pin,
    output logic mdc_pin,
    output logic mdio_drv,
    output logic mdio_en
);
    logic tx_clk_q = 1'b0;

    initial begin
        {tx_en_pin, txd_pin} = 5'h00;
        mdc_pin = 1'b0;
        mdio_drv = 1'b1;
        mdio_en = 1'b0;
    end

    // Launch on the falling edge so the device sees settled data on the rise
    always @(posedge clock) begin
        tx_clk_q <= tx_clk_out;
        if (tx_clk_q && !tx_clk_out) begin
            {tx_en_pin, txd_pin} <= tx_val;
        end
    end

    // One whole frame with its own preamble; clock stands low between frames
    task automatic mgmt_frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] reg_a,
            input logic [15:0] wdata, output logic [15:0] rdata);
        logic [63:0] bits;
        bits = {32'hffffffff, 2'b01, op, phy, reg_a, 2'b10, wdata};
        rdata = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            @(posedge clock);
            mdc_pin <= 1'b0;
            mdio_drv <= bits[i];
            mdio_en <= (op == mps_pkg::MDIO_OP_WRITE) || (i > 17);
            repeat (4) @(posedge clock);
            mdc_pin <= 1'b1;
            repeat (3) @(posedge clock);
            // Late in the bit: the device changes data only after a fall
            if (i < 16) rdata[i] = mdio_wire;
        end
        @(posedge clock);
        mdc_pin <= 1'b0;
        mdio_en <= 1'b0;
    endtask : mgmt_frame
endmodule : mps_mac_model

//--- tb/mps_strap_irq_tb_top.sv
// Self-checking bench: strap capture over all modes, pin drive, clocks, interrupts, management.
// Assumes the MAC model sits on the pins and the checker is bound below.
`timescale 1ns/1ps
module mps_strap_irq_tb_top;
    localparam int HALF = 2;
    logic clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0] reg_addr = 5'h00, station_address, tx_val = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd;
    mps_pkg::mps_rx_t rx_pin_in, rx_pin_out, rx_src = 6'h00, tb_rx = 6'h00;
    mps_pkg::mps_mode_t iface_mode;
    logic [1:0] cfg_low_strap = 2'h0;
    logic [7:0] event_in = 8'h00;
    logic [3:0] txd_pin, txd;
    logic [5:0] s;
    logic rx_pin_oe_n, rx_clk_out, tx_clk_out, tx_en_pin, tx_en, mdc_pin, mdio_wire, mdio_out, mdio_oe_n;
    logic mdio_drv, mdio_en, iface_mode_reserved, duplex_mode, isolate_mode, irq_out;
    int error_cnt = 0, compares = 0;

    always #12.5 clock = ~clock;
    // Released lines fall back to the strap resistors or the pull-up
    assign rx_pin_in = (rx_pin_oe_n !== 1'b0) ? tb_rx : rx_pin_out;
    assign mdio_wire = (mdio_oe_n === 1'b0) ? mdio_out : (mdio_en ? mdio_drv : 1'b1);

    mps_strap_irq #(.CLK_HALF_CYC(HALF)) mps_strap_irq_i (.clock(clock), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_pin_in(rx_pin_in), .rx_pin_out(rx_pin_out), .rx_pin_oe_n(rx_pin_oe_n), .rx_src(rx_src),
        .rx_clk_out(rx_clk_out), .tx_clk_out(tx_clk_out), .tx_en_pin(tx_en_pin), .txd_pin(txd_pin),
        .tx_en(tx_en), .txd(txd), .mdc_pin(mdc_pin), .mdio_in(mdio_wire), .mdio_out(mdio_out),
        .mdio_oe_n(mdio_oe_n), .cfg_low_strap(cfg_low_strap), .event_in(event_in),
        .station_address(station_address), .iface_mode(iface_mode), .iface_mode_reserved(iface_mode_reserved),
        .duplex_mode(duplex_mode), .isolate_mode(isolate_mode), .irq_out(irq_out));

    mps_mac_model mps_mac_model_i (.clock(clock), .tx_clk_out(tx_clk_out), .tx_val(tx_val),
        .mdio_wire(mdio_wire), .tx_en_pin(tx_en_pin), .txd_pin(txd_pin), .mdc_pin(mdc_pin),
        .mdio_drv(mdio_drv), .mdio_en(mdio_en));

    task automatic final_report;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic rd_chk(input string what, input logic [4:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        check(what, reg_rdata, exp);
    endtask : rd_chk

    task automatic strap_reset(input logic [1:0] c);
        @(posedge clock);
        sys_rst <= 1'b1;
        tb_rx <= s;
        cfg_low_strap <= c;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        tb_rx <= ~s;
        repeat (3) @(posedge clock);
    endtask : strap_reset

    task automatic drive_rx(input logic [5:0] v);
        int n = 0;
        @(posedge clock);
        rx_src <= v;
        while (rx_pin_in !== v && n < 40) begin
            @(posedge clock);
            n++;
        end
        check("rx pins", {10'h0, rx_pin_in}, {10'h0, v});
        if (n == 40) final_report();
    endtask : drive_rx

    task automatic drive_tx(input logic [4:0] v);
        int n = 0;
        @(posedge clock);
        tx_val <= v;
        while ({tx_en, txd} !== v && n < 40) begin
            @(posedge clock);
            n++;
        end
        check("tx capture", {11'h0, tx_en, txd}, {11'h0, v});
        if (n == 40) final_report();
    endtask : drive_tx

    task automatic pulse_irq(input logic [7:0] ev, input logic [4:0] a, input logic [15:0] d, input logic lvl);
        @(posedge clock);
        event_in <= ev;
        @(posedge clock);
        event_in <= 8'h00;
        if (a != 5'h00) reg_write(a, d);
        repeat (3) @(posedge clock);
        check("irq level", {15'h0, irq_out}, {15'h0, lvl});
    endtask : pulse_irq

    initial begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        // Every mode code, one of them with the isolate strap up
        for (int m = 0; m < 8; m++) begin
            s = {m[2], m == 6, m[0], ~m[0], m[1], ~m[2]};
            strap_reset(m[1:0]);
            check("address", {11'h0, station_address}, {13'h0, s[1], s[2], s[3]});
            check("mode", {13'h0, iface_mode}, m[15:0]);
            check("reserved", {15'h0, iface_mode_reserved}, {15'h0, m == 3 || m == 7});
            check("dup iso", {13'h0, rx_pin_oe_n, isolate_mode, duplex_mode}, {13'h0, s[4], s[4], s[0]});
            rd_chk("control", mps_pkg::ADDR_CTRL0, {5'h0, s[4], 1'b0, s[0], 8'h00});
            rd_chk("straps", mps_pkg::ADDR_STRAP, {8'h00, s[1], s[2], s[3], m[1:0], s[0], s[5], s[4]});
        end
        drive_rx(6'h2d);
        drive_rx(6'h12);
        drive_tx(5'h1b);
        drive_tx(5'h04);
        rd_chk("irq reset", mps_pkg::ADDR_IRQ, 16'h0000);
        rd_chk("pol reset", mps_pkg::ADDR_CTRL1F, 16'h0000);
        reg_write(mps_pkg::ADDR_IRQ, 16'h0100);
        pulse_irq(8'h03, 5'h00, 16'h0000, 1'b0);
        rd_chk("irq status", mps_pkg::ADDR_IRQ, 16'h0103);
        pulse_irq(8'h00, mps_pkg::ADDR_IRQ, 16'h0101, 1'b1);
        rd_chk("irq cleared", mps_pkg::ADDR_IRQ, 16'h0102);
        pulse_irq(8'h00, mps_pkg::ADDR_CTRL1F, 16'h0200, 1'b0);
        pulse_irq(8'h00, mps_pkg::ADDR_IRQ, 16'h0200, 1'b1);
        rd_chk("polarity", mps_pkg::ADDR_CTRL1F, 16'h0200);
        reg_write(5'h05, 16'hffff);
        rd_chk("unmapped", 5'h05, 16'h0000);
        mps_mac_model_i.mgmt_frame(mps_pkg::MDIO_OP_READ, station_address, mps_pkg::ADDR_CTRL1F, 16'h0000, rd);
        check("mgmt read", rd, 16'h0200);
        mps_mac_model_i.mgmt_frame(mps_pkg::MDIO_OP_WRITE, station_address ^ 5'h01, 5'h00, 16'h0001, rd);
        rd_chk("wrong phy", mps_pkg::ADDR_CTRL0, 16'h0000);
        mps_mac_model_i.mgmt_frame(mps_pkg::MDIO_OP_WRITE, station_address, 5'h00, 16'h0001, rd);
        repeat (4) @(posedge clock);
        rd_chk("mgmt write", mps_pkg::ADDR_CTRL0, 16'h0001);
        final_report();
    end

    initial begin
        repeat (40000) @(posedge clock);
        error_cnt++;
        final_report();
    end
endmodule : mps_strap_irq_tb_top

bind mps_strap_irq mps_strap_irq_properties #(.CLK_HALF_CYC(CLK_HALF_CYC)) mps_strap_irq_properties_i (
    .clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .event_in(event_in), .irq_out(irq_out), .rx_pin_oe_n(rx_pin_oe_n), .mdio_oe_n(mdio_oe_n),
    .rx_clk_out(rx_clk_out), .tx_clk_out(tx_clk_out), .station_address(station_address),
    .iface_mode(iface_mode), .iface_mode_reserved(iface_mode_reserved), .isolate_mode(isolate_mode));
